// ---- owcs_clock_select.sv ----
`timescale 1ns/10ps
`default_nettype none
module owcs_clock_select #(
  parameter int SUP_LIMIT = owcs_pkg::SUPERVISION_LIMIT
) (
  input wire logic clk_sys, // PLL-side clock, 50 MHz
  input wire logic rstn, // synchronous reset, active low
  input wire logic external_clock_input_pin, // oscillator input level
  input wire logic [2:0] clock_mode_strap_bits, // straps, held in reset
  input wire logic [7:0] system_config_register, // config byte
  input wire logic clock_fail_irq_clear, // software clear pulse
  output logic clock_fail_interrupt_request, // sticky failure flag
  output logic pll_resync, // resync pulse in PLL mode
  output owcs_pkg::owcs_status_t clock_status // selection state
);

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  logic [2:0] strap_reg;
  logic [2:0] strap_next;

  // straps only move while reset is held
  // straps sampled
  assign strap_next = rstn ? strap_reg : clock_mode_strap_bits;

  always_ff @(posedge clk_sys) begin
    strap_reg <= strap_next;
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  // direct code
  wire mode_direct = (strap_reg == owcs_pkg::STRAP_DIRECT);
  wire mode_prescale = (strap_reg == owcs_pkg::STRAP_PRESCALE);
  wire mode_supervised = mode_direct | mode_prescale;
  wire sup_disabled =
    system_config_register[owcs_pkg::SUPERVISION_DISABLE_POS];
  wire sup_on = mode_supervised & ~sup_disabled;

  function automatic logic [3:0] factor_half(input logic [2:0] code);
    logic [3:0] f;
    f = owcs_pkg::HALF_X1;
    unique case (code)
      owcs_pkg::STRAP_X4: f = owcs_pkg::HALF_X4;
      owcs_pkg::STRAP_X3: f = owcs_pkg::HALF_X3;
      owcs_pkg::STRAP_X2: f = owcs_pkg::HALF_X2;
      owcs_pkg::STRAP_X5: f = owcs_pkg::HALF_X5;
      owcs_pkg::STRAP_X1P5: f = owcs_pkg::HALF_X1P5;
      owcs_pkg::STRAP_X2P5: f = owcs_pkg::HALF_X2P5;
      default: f = owcs_pkg::HALF_X1;
    endcase
    return f;
  endfunction : factor_half

  wire [3:0] factor_h = factor_half(strap_reg);

  // ----------------------------------------------------------------
  // input transition detect
  // ----------------------------------------------------------------
  localparam int SYNC_W = owcs_pkg::SYNC_STAGES;
  logic [SYNC_W-1:0] sync_reg;
  logic last_reg;

  // two-stage sync
  // first stage feeds only the second, it may be metastable
  always_ff @(posedge clk_sys) begin
    sync_reg <= {sync_reg[SYNC_W-2:0], external_clock_input_pin};
    last_reg <= sync_reg[SYNC_W-1];
  end

  wire xtal_edge = sync_reg[SYNC_W-1] ^ last_reg;

  // ----------------------------------------------------------------
  // supervision counter
  // ----------------------------------------------------------------
  logic [owcs_pkg::SUP_CNT_W-1:0] sup_cnt_reg;
  logic [owcs_pkg::SUP_CNT_W-1:0] sup_cnt_next;
  logic fallback_reg;
  logic fallback_next;

  localparam logic [owcs_pkg::SUP_CNT_W-1:0] SUP_LAST =
    owcs_pkg::SUP_CNT_W'(SUP_LIMIT - 1);
  localparam logic [owcs_pkg::SUP_CNT_W-1:0] SUP_ONE =
    owcs_pkg::SUP_CNT_W'(1);

  wire sup_at_last = (sup_cnt_reg == SUP_LAST);
  wire sup_overflow = sup_on & ~xtal_edge & sup_at_last;
  wire fail_event = sup_overflow & ~fallback_reg;

  // clear on edge
  // counter parked at zero once fallen back, no second failure
  wire sup_clear = ~sup_on | xtal_edge | fallback_reg;
  wire [owcs_pkg::SUP_CNT_W-1:0] sup_cnt_inc = sup_cnt_reg + SUP_ONE;
  assign sup_cnt_next = sup_clear ? '0 :
    (sup_overflow ? sup_cnt_reg : sup_cnt_inc);
  assign fallback_next = fallback_reg | sup_overflow;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sup_cnt_reg <= '0;
    end else begin
      sup_cnt_reg <= sup_cnt_next;
    end
  end

  // only a hardware reset releases the fallback
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      fallback_reg <= 1'b0;
    end else begin
      fallback_reg <= fallback_next;
    end
  end

  // ----------------------------------------------------------------
  // interrupt request flag
  // ----------------------------------------------------------------
  logic irq_reg;
  logic irq_next;

  // a clear in the failing cycle is lost
  // flag on failure
  assign irq_next = fail_event | (irq_reg & ~clock_fail_irq_clear);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign clock_fail_interrupt_request = irq_reg;

  // ----------------------------------------------------------------
  // PLL resynchronisation
  // ----------------------------------------------------------------
  logic [3:0] edge_cnt_reg;
  logic [3:0] edge_cnt_next;
  logic resync_reg;

  // F-th transition: factor in halves for fractional F
  wire [3:0] resync_period = factor_h[0] ? factor_h : (factor_h >> 1);
  wire [3:0] resync_last = resync_period - 4'h1;
  wire pll_mode = ~mode_supervised;
  wire resync_hit = pll_mode & xtal_edge & (edge_cnt_reg == resync_last);
  wire [3:0] edge_cnt_inc = edge_cnt_reg + 4'h1;

  assign edge_cnt_next = (!pll_mode || resync_hit) ? 4'h0 :
    (xtal_edge ? edge_cnt_inc : edge_cnt_reg);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      edge_cnt_reg <= 4'h0;
    end else begin
      edge_cnt_reg <= edge_cnt_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      resync_reg <= 1'b0;
    end else begin
      resync_reg <= resync_hit;
    end
  end

  assign pll_resync = resync_reg;

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  owcs_pkg::owcs_src_t src_sel;
  owcs_pkg::owcs_status_t status_reg;
  owcs_pkg::owcs_status_t status_next;

  assign src_sel = fallback_reg ? owcs_pkg::OWCS_SRC_FALLBACK :
    (mode_direct ? owcs_pkg::OWCS_SRC_DIRECT :
    (mode_prescale ? owcs_pkg::OWCS_SRC_PRESCALE :
    owcs_pkg::OWCS_SRC_PLL));

  wire pll_on = pll_mode | sup_on | fallback_reg;
  wire pll_free = mode_supervised & (sup_on | fallback_reg);
  wire [3:0] factor_out = pll_mode ? factor_h : owcs_pkg::HALF_X1;
  wire sup_watching = sup_on & ~fallback_reg;

  always_comb begin
    status_next.cpu_clock_source = src_sel;
    status_next.pll_enable = pll_on;
    status_next.pll_free_running = pll_free;
    status_next.pll_factor_half = factor_out;
    status_next.supervision_active = sup_watching;
  end

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  // all fields move on one edge, no mixed selection is seen
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  assign clock_status = status_reg;

endmodule : owcs_clock_select
`default_nettype wire

// ---- owcs_osc_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module owcs_osc_model (
  input wire logic clk_sys, // bench clock
  input wire logic run, // oscillate when high
  output logic pin // oscillator output
);
  logic [1:0] div_reg;
  // toggle every third cycle, hold level when stopped
  initial begin
    pin = 1'b0;
    div_reg = 2'h0;
    forever begin
      @(posedge clk_sys);
      div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
      if (run && div_reg == 2'h2)
        pin <= ~pin;
    end
  end
endmodule : owcs_osc_model
`default_nettype wire

// ---- owcs_pkg.sv ----
// Behaviour
// - supervision acts only in direct drive or prescaler clock modes.
// - supervision on after reset; disable bit (config bit 4) turns it off.
// - supervision enabled keeps PLL free-running; counter advances per PLL cycle.
// - any rising or falling input clock transition clears the counter.
// - sixteen PLL cycles without a transition mean input clock failure.
// - on failure switch CPU clock to PLL and flag the interrupt request.
// - fallback holds despite returning clock until a hardware reset.
// - supervision disabled: CPU clock from oscillator input, PLL switched off.
// - other strap codes enable PLL, CPU clock is input times strap factor.
// - PLL resynchronises to input every F-th transition, smoothly.
// - three straps sampled in reset pick mode; factors 4,3,2,5,1.5,2.5.
// - strap code 011 gives direct drive from the input clock.
// - strap code 001 gives input clock divided by two.
package owcs_pkg;

  // ----------------------------------------------------------------
  // strap codes
  // ----------------------------------------------------------------
  localparam logic [2:0] STRAP_X4 = 3'h7;
  localparam logic [2:0] STRAP_X3 = 3'h6;
  localparam logic [2:0] STRAP_X2 = 3'h5;
  localparam logic [2:0] STRAP_X5 = 3'h4;
  localparam logic [2:0] STRAP_DIRECT = 3'h3;
  localparam logic [2:0] STRAP_X1P5 = 3'h2;
  localparam logic [2:0] STRAP_PRESCALE = 3'h1;
  localparam logic [2:0] STRAP_X2P5 = 3'h0;
  localparam logic [2:0] STRAP_DEFAULT = STRAP_X4;

  // ----------------------------------------------------------------
  // supervision and config fields
  // ----------------------------------------------------------------
  localparam int SUPERVISION_DISABLE_POS = 4;
  localparam int SUPERVISION_LIMIT = 16;
  localparam int SUP_CNT_W = 5;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // factor encoding in halves (factor * 2)
  // ----------------------------------------------------------------
  localparam logic [3:0] HALF_X4 = 4'h8;
  localparam logic [3:0] HALF_X3 = 4'h6;
  localparam logic [3:0] HALF_X2 = 4'h4;
  localparam logic [3:0] HALF_X5 = 4'hA;
  localparam logic [3:0] HALF_X1 = 4'h2;
  localparam logic [3:0] HALF_X1P5 = 4'h3;
  localparam logic [3:0] HALF_X2P5 = 4'h5;

  typedef enum logic [1:0] {
    OWCS_SRC_DIRECT = 2'b00,
    OWCS_SRC_PRESCALE = 2'b01,
    OWCS_SRC_PLL = 2'b10,
    OWCS_SRC_FALLBACK = 2'b11
  } owcs_src_t;

  typedef struct packed {
    owcs_src_t cpu_clock_source;
    logic pll_enable;
    logic pll_free_running;
    logic [3:0] pll_factor_half;
    logic supervision_active;
  } owcs_status_t;

endpackage : owcs_pkg

// ---- owcs_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module owcs_props #(
  parameter int SUP_LIMIT = 16
) (
  input wire logic clk_sys, // clock
  input wire logic rstn, // reset
  input wire logic external_clock_input_pin, // osc pin
  input wire logic [2:0] clock_mode_strap_bits, // straps
  input wire logic [7:0] system_config_register, // config
  input wire logic clock_fail_irq_clear, // clear
  input wire logic clock_fail_interrupt_request, // flag
  input wire logic pll_resync, // resync
  input wire owcs_pkg::owcs_status_t clock_status // status
);
  logic [7:0] quiet_reg;
  logic [1:0] src;
  logic irq;
  logic dis;
  logic sup;
  assign src = clock_status.cpu_clock_source;
  assign irq = clock_fail_interrupt_request;
  assign dis = system_config_register[owcs_pkg::SUPERVISION_DISABLE_POS];
  assign sup = clock_status.supervision_active;
  // cycles since the pin last moved
  always_ff @(posedge clk_sys) begin
    if (!rstn || external_clock_input_pin != $past(external_clock_input_pin))
      quiet_reg <= 8'h00;
    else if (quiet_reg != 8'hFF)
      quiet_reg <= quiet_reg + 8'h01;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence fail_seq;
    $rose(irq);
  endsequence
  fail_switch_a: assert property (fail_seq |=> src == 2'h3)
    else $error("no fallback after failure");
  fail_count_a: assert property (fail_seq |->
    quiet_reg >= SUP_LIMIT && quiet_reg <= SUP_LIMIT + 6)
    else $error("failure flagged at wrong count");
  fallback_hold_a: assert property (src == 2'h3 |=> src == 2'h3)
    else $error("fallback left without reset");
  irq_sticky_a: assert property (irq && !clock_fail_irq_clear |=> irq)
    else $error("request dropped without clear");
  irq_clear_a: assert property (irq && clock_fail_irq_clear
    && src == 2'h3 |=> !irq) else $error("clear ignored");
  pll_no_fail_a: assert property (src == 2'h2 |-> !irq)
    else $error("failure in multiply mode");
  sup_pll_a: assert property (src[1] == 1'b0 && !dis && !$past(dis)
    && $past(rstn) |-> sup && clock_status.pll_free_running)
    else $error("supervision off while enabled");
  disabled_off_a: assert property (src[1] == 1'b0 && dis && $past(dis)
    |-> !sup && !clock_status.pll_enable) else $error("pll not off");
  resync_pll_a: assert property (pll_resync |-> src == 2'h2)
    else $error("resync outside multiply mode");
endmodule : owcs_props
bind owcs_clock_select owcs_props #(.SUP_LIMIT(SUP_LIMIT)) u_props (
  .clk_sys(clk_sys), .rstn(rstn),
  .external_clock_input_pin(external_clock_input_pin),
  .clock_mode_strap_bits(clock_mode_strap_bits),
  .system_config_register(system_config_register),
  .clock_fail_irq_clear(clock_fail_irq_clear),
  .clock_fail_interrupt_request(clock_fail_interrupt_request),
  .pll_resync(pll_resync), .clock_status(clock_status));
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef struct {logic [2:0] s; logic [1:0] src; logic [3:0] f;} owcs_row_t;
  logic clk_sys, rstn, run, irq_clr, pin, irq, resync;
  logic [2:0] strap;
  logic [7:0] cfg;
  owcs_pkg::owcs_status_t st;
  int n_mismatch = 0;
  int check_count = 0;
  int k, n;
  owcs_row_t rows[8] = '{'{3'h7, 2'h2, 4'h8}, '{3'h6, 2'h2, 4'h6},
    '{3'h5, 2'h2, 4'h4}, '{3'h4, 2'h2, 4'hA}, '{3'h3, 2'h0, 4'h2},
    '{3'h2, 2'h2, 4'h3}, '{3'h1, 2'h1, 4'h2}, '{3'h0, 2'h2, 4'h5}};
  owcs_osc_model osc (.clk_sys(clk_sys), .run(run), .pin(pin));
  owcs_clock_select dut (.clk_sys(clk_sys), .rstn(rstn),
    .external_clock_input_pin(pin), .clock_mode_strap_bits(strap),
    .system_config_register(cfg), .clock_fail_irq_clear(irq_clr),
    .clock_fail_interrupt_request(irq), .pll_resync(resync),
    .clock_status(st));
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic go(int c);
    repeat (c) @(posedge clk_sys);
  endtask : go
  task automatic do_reset(logic [2:0] s);
    rstn <= 1'b0;
    strap <= s;
    go(16);
    rstn <= 1'b1;
    go(3);
  endtask : do_reset
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    go(20000);
    n_mismatch++;
    summarize();
  end
  initial begin
    run = 1'b1;
    irq_clr = 1'b0;
    cfg = 8'h00;
    for (k = 0; k < 8; k++) begin
      do_reset(rows[k].s);
      check("src", 8'(st.cpu_clock_source), 8'(rows[k].src));
      check("factor", 8'(st.pll_factor_half), 8'(rows[k].f));
    end
    do_reset(3'h7);
    n = 0;
    repeat (120) begin
      @(posedge clk_sys);
      n += int'(resync);
    end
    check("resync", 8'(n >= 9 && n <= 11), 8'h01);
    run <= 1'b0;
    go(40);
    check("pll_irq", 8'(irq), 8'h00);
    run <= 1'b1;
    do_reset(3'h3);
    run <= 1'b0;
    go(12);
    check("early_irq", 8'(irq), 8'h00);
    go(14);
    check("irq", 8'(irq), 8'h01);
    check("fallback", 8'(st.cpu_clock_source), 8'h03);
    run <= 1'b1;
    irq_clr <= 1'b1;
    go(1);
    irq_clr <= 1'b0;
    go(20);
    check("cleared", 8'(irq), 8'h00);
    check("held", 8'(st.cpu_clock_source), 8'h03);
    do_reset(3'h3);
    check("restored", 8'(st.cpu_clock_source), 8'h00);
    check("sup_on", 8'(st.supervision_active), 8'h01);
    check("free_run", 8'(st.pll_free_running), 8'h01);
    go(40);
    check("run_irq", 8'(irq), 8'h00);
    cfg <= 8'h10;
    go(2);
    run <= 1'b0;
    go(40);
    check("dis_irq", 8'(irq), 8'h00);
    check("dis_sup", 8'(st.supervision_active), 8'h00);
    check("pll_off", 8'(st.pll_enable), 8'h00);
    cfg <= 8'h00;
    do_reset(3'h1);
    run <= 1'b0;
    go(30);
    check("pre_fall", 8'(st.cpu_clock_source), 8'h03);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
